// ### scif_pkg.sv
// Package with register map, field layout and bus types of the flag block.
package scif_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the registers.
  localparam logic [7:0] OFF_ENABLE_CLR = 8'h00;
  localparam logic [7:0] OFF_ENABLE_SET = 8'h04;
  localparam logic [7:0] OFF_FLAGS      = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;

  // Bits that hold a flag and an enable; all others are reserved.
  localparam logic [31:0] FLAG_MASK  = 32'h0003_8FFF;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
  localparam logic [31:0] EN_RESET   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  localparam int unsigned NUM_SRC = 32;

  // Field positions of the status sources.
  localparam int unsigned BIT_CRYSTAL_OSC_READY     = 0;
  localparam int unsigned BIT_CRYSTAL_32K_OSC_READY = 1;
  localparam int unsigned BIT_INTERNAL_32K_OSC_READY = 2;
  localparam int unsigned BIT_INTERNAL_8MHZ_OSC_READY = 3;
  localparam int unsigned BIT_FLL_READY             = 4;
  localparam int unsigned BIT_FLL_OUT_OF_BOUNDS     = 5;
  localparam int unsigned BIT_FLL_FINE_LOCK         = 6;
  localparam int unsigned BIT_FLL_COARSE_LOCK       = 7;
  localparam int unsigned BIT_FLL_REF_CLOCK_STOPPED = 8;
  localparam int unsigned BIT_BROWNOUT_READY        = 9;
  localparam int unsigned BIT_BROWNOUT_DETECTED     = 10;
  localparam int unsigned BIT_BROWNOUT_SYNC_READY   = 11;
  localparam int unsigned BIT_PLL_LOCK_RISE         = 15;
  localparam int unsigned BIT_PLL_LOCK_FALL         = 16;
  localparam int unsigned BIT_PLL_LOCK_TIMEOUT      = 17;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } scif_req_t;

  // Avalon-MM answer to the master.
  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic [1:0]        response;
  } scif_rsp_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ### scif_flag_cell.sv
// One interrupt flag with its rising-edge detector, enable and clear.
`timescale 1ns/1ps

module scif_flag_cell
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Synchronised status level and software strobes.
  input  wire logic status_sync,
  input  wire logic flag_clear,
  input  wire logic enable_set,
  input  wire logic enable_clear,
  // State.
  output logic      flag,
  output logic      enable
);

  typedef struct packed {
    logic last;
    logic flag;
    logic enable;
  } scif_cell_t;

  scif_cell_t s_q;
  scif_cell_t s_d;
  logic       rise;

  always_comb
  begin
    s_d      = s_q;
    rise     = status_sync & ~s_q.last;
    s_d.last = status_sync;
    // The event wins over a clear in the same cycle.
    if (rise)
    begin
      s_d.flag = 1'b1;
    end
    else if (flag_clear)
    begin
      s_d.flag = 1'b0;
    end
    if (enable_set)
    begin
      s_d.enable = 1'b1;
    end
    else if (enable_clear)
    begin
      s_d.enable = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign flag   = s_q.flag;
  assign enable = s_q.enable;

endmodule

// ### scif_top.sv
// Clock event flag and enable registers with an Avalon-MM slave port.
//
// Function
// - Writing one to enable-set bit 2 sets internal 32k ready enable.
// - Writing one to enable-set bit 1 sets crystal 32k ready enable.
// - Writing one to enable-set bit 0 sets crystal ready enable.
// - An enabled flag that is set raises the interrupt request.
// - Flag 17 sets on rising pll lock timeout status.
// - Flag 16 sets on rising pll lock fall status.
// - Flag 15 sets on rising pll lock rise status.
// - Flag 11 sets on rising brownout sync ready status.
// - Flag 10 sets on rising brownout detected status.
// - Flag 9 sets on rising brownout ready status.
// - Flag 8 sets on rising fll reference clock stopped status.
// - Flag 7 sets on rising fll coarse lock status.
// - Flag 6 sets on rising fll fine lock status.
// - Flag 5 sets on rising fll out of bounds status.
// - Flag 4 sets on rising fll ready status.
// - Flag 3 sets on rising internal 8 MHz oscillator ready status.
// - Flag 2 sets on rising internal 32k oscillator ready status.
// - Flag 1 sets on rising crystal 32k oscillator ready status.
// - Writing one clears a flag; writing zero leaves it.
// - Flags reset to zero; reserved bits are read-only.
// - Flag 0 sets on rising crystal oscillator ready status.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

module scif_top
(
  // Clock and reset.
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Avalon-MM slave.
  input  wire scif_pkg::scif_req_t        avs_req,
  output scif_pkg::scif_rsp_t             avs_rsp,
  // Status levels from the oscillators, loops and brown-out detector.
  input  wire logic [31:0]                power_clock_status,
  // Interrupt request.
  output logic                            irq
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DONE
  } scif_state_t;

  typedef struct packed {
    logic [31:0]         sync1;
    logic [31:0]         sync2;
    scif_state_t         state;
    logic [31:0]         readdata;
    logic [1:0]          response;
    logic                waitrequest;
    logic                irq;
  } scif_top_t;

  scif_top_t s_q;
  scif_top_t s_d;

  logic [31:0] flags;
  logic [31:0] enables;
  logic [31:0] wr_mask;
  logic        acc;
  logic        wr_go;
  logic        hit_flags;
  logic        hit_set;
  logic        hit_clr;

  // Byte enables widened to a bit mask.
  always_comb
  begin
    wr_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
               {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
  end

  // A request is taken in the idle state and committed exactly once.
  assign acc       = (avs_req.read | avs_req.write) && s_q.state == ST_IDLE;
  assign wr_go     = acc & avs_req.write;
  assign hit_flags = avs_req.address == scif_pkg::OFF_FLAGS;
  assign hit_set   = avs_req.address == scif_pkg::OFF_ENABLE_SET;
  assign hit_clr   = avs_req.address == scif_pkg::OFF_ENABLE_CLR;

  // One cell per implemented bit; reserved bits have no storage.
  for (genvar i = 0; i < scif_pkg::NUM_SRC; i++)
  begin : g_cell
    if (scif_pkg::FLAG_MASK[i])
    begin : g_used
      scif_flag_cell u_cell
      (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .status_sync  (s_q.sync2[i]),
        .flag_clear   (wr_go & hit_flags & avs_req.writedata[i] & wr_mask[i]),
        .enable_set   (wr_go & hit_set & avs_req.writedata[i] & wr_mask[i]),
        .enable_clear (wr_go & hit_clr & avs_req.writedata[i] & wr_mask[i]),
        .flag         (flags[i]),
        .enable       (enables[i])
      );
    end
    else
    begin : g_rsvd
      assign flags[i]   = 1'b0;
      assign enables[i] = 1'b0;
    end
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = power_clock_status & scif_pkg::FLAG_MASK;
    s_d.sync2 = s_q.sync1;
    s_d.irq   = |(flags & enables);
    case (s_q.state)
      ST_IDLE:
      begin
        s_d.waitrequest = 1'b1;
        if (acc)
        begin
          s_d.state       = ST_DONE;
          s_d.waitrequest = 1'b0;
          s_d.response    = scif_pkg::RESP_OKAY;
          s_d.readdata    = scif_pkg::READ_ZERO;
          if (hit_flags)
          begin
            s_d.readdata = flags;
          end
          else if (hit_set || hit_clr)
          begin
            s_d.readdata = enables;
          end
          else if (avs_req.address == scif_pkg::OFF_STATUS)
          begin
            s_d.readdata = s_q.sync2;
          end
          else
          begin
            s_d.response = scif_pkg::RESP_DECERR;
          end
        end
      end
      ST_DONE:
      begin
        s_d.state       = ST_IDLE;
        s_d.waitrequest = 1'b1;
      end
      default:
      begin
        s_d.state       = ST_IDLE;
        s_d.waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q             <= '0;
      s_q.state       <= ST_IDLE;
      s_q.waitrequest <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_rsp.readdata    = s_q.readdata;
  assign avs_rsp.waitrequest = s_q.waitrequest;
  assign avs_rsp.response    = s_q.response;
  assign irq                 = s_q.irq;

endmodule

// ### scif_asserts.sv
// Checker for bus timing, reserved bits and the interrupt output.
`timescale 1ns/1ps

module scif_asserts
(
  // Clock and reset.
  input wire logic                sys_clk,
  input wire logic                rst_n,
  // Watched ports.
  input wire scif_pkg::scif_req_t avs_req,
  input wire scif_pkg::scif_rsp_t avs_rsp,
  input wire logic [31:0]         power_clock_status,
  input wire logic                irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic tk;
  logic rt;
  assign tk = (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
  assign rt = tk && avs_req.read;
  a_one_wait: assert property (tk |=> !avs_rsp.waitrequest ##1
    avs_rsp.waitrequest) else $error("wait state count wrong");
  a_idle_wait: assert property (!avs_req.read && !avs_req.write &&
    avs_rsp.waitrequest |=> avs_rsp.waitrequest) else $error("idle answer");
  a_bad_addr: assert property (rt && avs_req.address == 8'h10 |=>
    avs_rsp.readdata == 32'h0 && avs_rsp.response == scif_pkg::RESP_DECERR)
    else $error("unmapped read answer wrong");
  a_flag_rsvd: assert property (rt && avs_req.address == scif_pkg::OFF_FLAGS
    |=> (avs_rsp.readdata & ~scif_pkg::FLAG_MASK) == 32'h0)
    else $error("reserved flag bit set");
  a_en_rsvd: assert property (rt && avs_req.address == 8'h04
    |=> (avs_rsp.readdata & ~scif_pkg::FLAG_MASK) == 32'h0)
    else $error("reserved enable bit set");
  a_irq_reset: assert property ($rose(rst_n) |-> !irq)
    else $error("irq high after reset");
  a_irq_off: assert property (tk && avs_req.write && avs_req.address == 8'h00
    && avs_req.writedata == 32'hFFFFFFFF && avs_req.byteenable == 4'hF
    |=> ##1 !irq) else $error("irq high with enables cleared");
  a_rsp_hold: assert property (!tk |=> $stable(avs_rsp.readdata))
    else $error("read data changed outside access");
endmodule

// ### test_sysctrl_clock_irq_flags.sv
// Self-checking bench of the clock event flag block.
`timescale 1ns/1ps

module test_sysctrl_clock_irq_flags;
  logic                sys_clk;
  logic                rst_n;
  scif_pkg::scif_req_t req;
  scif_pkg::scif_rsp_t rsp;
  logic [31:0]         status;
  logic                irq;
  logic [32:0]         exp_q[$];
  logic [31:0]         flg;
  logic [31:0]         en;
  logic [31:0]         m;
  logic [31:0]         wd;
  int                  fail_count;
  int                  num_checks;
  int                  seed;

  scif_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_req(req),
    .avs_rsp(rsp), .power_clock_status(status), .irq(irq));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.address <= a;
    req.read <= !w;
    req.write <= w;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  // The irq level is expected alongside the read data.
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({|(flg & en), e});
    acc(1'b0, a, 32'h0);
  endtask

  task rise(input logic [31:0] v);
    @(posedge sys_clk);
    flg = flg | (v & ~status & scif_pkg::FLAG_MASK);
    status <= v;
    repeat (6) @(posedge sys_clk);
  endtask

  task check(input logic [32:0] got, input logic [32:0] e);
    num_checks++;
    if (got !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  always @(posedge sys_clk)
    if (rst_n === 1'b1 && req.read === 1'b1 && rsp.waitrequest === 1'b0)
      check({irq, rsp.readdata}, exp_q.pop_front());

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end

  initial
  begin
    seed = 47;
    rst_n = 1'b0;
    status = 32'h0;
    req = '0;
    flg = 32'h0;
    en = 32'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(scif_pkg::OFF_FLAGS, 32'h0);
    acc(1'b1, scif_pkg::OFF_FLAGS, 32'hFFFFFFFF);
    acc(1'b1, 8'h10, 32'hFFFFFFFF);
    rd(scif_pkg::OFF_ENABLE_SET, 32'h0);
    rd(8'h10, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 32; i++)
      if (scif_pkg::FLAG_MASK[i])
      begin
        m = 32'h1 << i;
        rise(m);
        rd(scif_pkg::OFF_FLAGS, flg);
        acc(1'b1, scif_pkg::OFF_ENABLE_SET, 32'h0);
        rd(scif_pkg::OFF_ENABLE_SET, en);
        acc(1'b1, scif_pkg::OFF_ENABLE_SET, m);
        en = en | m;
        rd(scif_pkg::OFF_FLAGS, flg);
        acc(1'b1, scif_pkg::OFF_FLAGS, ~m);
        rd(scif_pkg::OFF_FLAGS, flg);
        acc(1'b1, scif_pkg::OFF_FLAGS, m);
        flg = flg & ~m;
        rd(scif_pkg::OFF_FLAGS, flg);
        acc(1'b1, scif_pkg::OFF_ENABLE_CLR, 32'hFFFFFFFF);
        en = 32'h0;
        status <= 32'h0;
      end
    $display("single flag test done");
    // A status rise lands on the same edge as a write-one clear.
    m = 32'h1 << scif_pkg::BIT_PLL_LOCK_TIMEOUT;
    @(posedge sys_clk);
    status <= m;
    @(posedge sys_clk);
    acc(1'b1, scif_pkg::OFF_FLAGS, m);
    flg = flg | m;
    rd(scif_pkg::OFF_FLAGS, flg);
    acc(1'b1, scif_pkg::OFF_FLAGS, m);
    flg = flg & ~m;
    status <= 32'h0;
    rd(scif_pkg::OFF_FLAGS, flg);
    $display("set beats clear test done");
    repeat (8)
    begin
      rise($random(seed));
      rd(scif_pkg::OFF_FLAGS, flg);
      rd(scif_pkg::OFF_STATUS, status & scif_pkg::FLAG_MASK);
      wd = $random(seed);
      acc(1'b1, scif_pkg::OFF_ENABLE_SET, wd);
      en = en | (wd & scif_pkg::FLAG_MASK);
      wd = $random(seed);
      acc(1'b1, scif_pkg::OFF_FLAGS, wd);
      flg = flg & ~wd;
      rd(scif_pkg::OFF_FLAGS, flg);
      acc(1'b1, scif_pkg::OFF_ENABLE_CLR, 32'hFFFFFFFF);
      en = 32'h0;
    end
    $display("random test done");
    stop_test;
  end
endmodule

bind scif_top scif_asserts chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_req(avs_req), .avs_rsp(avs_rsp),
  .power_clock_status(power_clock_status), .irq(irq));
